// File: rtl/apd_consts.svh
/*
 Constants for the pacer and DMA request block: offsets, fields, values, counts.
 Assumes inclusion by the package and modules; definitions only.
*/
`ifndef APD_CONSTS_SVH
`define APD_CONSTS_SVH
`define APD_OFF_DMA_CTRL 4'h9
`define APD_OFF_PACER_EN 4'ha
`define APD_OFF_DIV1 4'hd
`define APD_OFF_DIV2 4'he
`define APD_OFF_MODE 4'hf
`define APD_OFF_STATUS 4'h0
`define APD_MODE_CNT1_SQ 8'h76
`define APD_MODE_CNT2_SQ 8'hb6
`define APD_CTRL_DMA_EN_BIT 2
`define APD_CTRL_SRC_LO 0
`define APD_CTRL_RESET 8'h00
`define APD_PACER_EN_RESET 8'h01
`define APD_CLK_HZ 10000000
`define APD_BASE_HI_HZ 10000000
`define APD_BASE_LO_HZ 1000000
`define APD_BASE_LO_DIV (`APD_CLK_HZ / `APD_BASE_LO_HZ)
`define APD_BASE_HI_DIV (`APD_CLK_HZ / `APD_BASE_HI_HZ)
`define APD_SRC_PACER 2'h3
`define APD_SRC_EXT 2'h2
`endif

// File: rtl/apd_pkg.sv
/*
 Types shared by both ends of the pacer and DMA request link.
 Assumes the constants header is available for include.
*/
package apd_pkg;
   typedef logic [3:0] apd_addr_t;
   typedef logic [7:0] apd_byte_t;
   typedef enum logic [2:0] {
      APD_H_IDLE = 3'h1,
      APD_H_WAIT = 3'h2,
      APD_H_ACK = 3'h4
   } apd_host_state_t;
endpackage

// File: rtl/apd_link_if.sv
/*
 Link between the acquisition device and the host side: byte-wide I/O cycle,
 DMA request and acknowledge. Assumes one common clock.
*/
`timescale 1ns/1ps
interface apd_link_if;
   logic [3:0] io_addr;
   logic [7:0] io_wdata;
   logic io_wr;
   logic io_rd;
   logic [7:0] io_rdata;
   logic dma_req;
   logic dma_ack;
   modport dev (
      input io_addr,
      input io_wdata,
      input io_wr,
      input io_rd,
      output io_rdata,
      output dma_req,
      input dma_ack
   );
   modport host (
      output io_addr,
      output io_wdata,
      output io_wr,
      output io_rd,
      input io_rdata,
      input dma_req,
      output dma_ack
   );
endinterface

// File: rtl/apd_sq_counter.sv
/*
 One 16-bit square-wave counter, advanced by a one-cycle count enable.
 Assumes divisor loads come as a whole word with a load strobe.
*/
`timescale 1ns/1ps
module apd_sq_counter (
   input wire logic clock,
   input wire logic rstn,
   input wire logic armed,
   input wire logic load,
   input wire logic [15:0] divisor,
   input wire logic tick,
   output logic out_q,
   output logic edge_q
);
   import apd_pkg::*;
   logic [15:0] cnt_q;
   logic [15:0] div_q;
   logic run_q;

   // High for (N+1)/2 ticks and low for N/2 ticks, both rounded down, repeating.
   function automatic logic [15:0] half(input logic [15:0] n, input logic hi);
      // The sum is widened so that a divisor of 65535 does not wrap to zero.
      half = hi ? 16'((17'(n) + 17'h00001) >> 1) : 16'(n >> 1);
   endfunction

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         div_q <= 16'h0002;
         run_q <= 1'b0;
      end else if (load) begin
         div_q <= divisor;
         run_q <= armed;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= 16'h0001;
         out_q <= 1'b1;
         edge_q <= 1'b0;
      end else begin
         edge_q <= 1'b0;
         if (load) begin
            cnt_q <= half(divisor, 1'b1);
            out_q <= 1'b1;
         end else if (run_q && tick) begin
            if (cnt_q <= 16'h0001) begin
               out_q <= ~out_q;
               edge_q <= out_q;
               cnt_q <= half(div_q, ~out_q);
            end else begin
               cnt_q <= cnt_q - 16'h0001;
            end
         end
      end
   end
endmodule

// File: rtl/apd_device.sv
/*
 Device end: pacer made of two cascaded square-wave counters and a DMA request
 per trigger. Assumes the host end drives byte I/O cycles on the shared clock.
*/
// Chosen here: strobed register access.
`timescale 1ns/1ps
`include "apd_consts.svh"
module apd_device (
   input wire logic clock,
   input wire logic rstn,
   apd_link_if.dev link,
   input wire logic base_clock_select,
   input wire logic dma_channel_select,
   input wire logic ext_trigger,
   output logic conv_start_q,
   output logic dma_ch1_req_q,
   output logic dma_ch3_req_q
);
   import apd_pkg::*;
   logic [7:0] ctrl_q;
   logic [7:0] pacer_en_q;
   logic [7:0] div1_lo_q;
   logic [7:0] div1_hi_q;
   logic [7:0] div2_lo_q;
   logic [7:0] div2_hi_q;
   logic div1_hi_next_q;
   logic div2_hi_next_q;
   logic mode1_q;
   logic mode2_q;
   logic load1_q;
   logic load2_q;
   logic [3:0] pre_q;
   logic base_tick_q;
   logic sel_s1_q, sel_s2_q, ch_s1_q, ch_s2_q, ext_s1_q, ext_s2_q, ext_s3_q;
   logic out1, edge1, out2, edge2;
   logic req_q;
   logic [7:0] rdata_q;
   logic trig;
   logic [3:0] base_div;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         sel_s1_q <= 1'b0;
         sel_s2_q <= 1'b0;
         ch_s1_q <= 1'b0;
         ch_s2_q <= 1'b0;
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
         ext_s3_q <= 1'b0;
      end else begin
         sel_s1_q <= base_clock_select;
         sel_s2_q <= sel_s1_q;
         ch_s1_q <= dma_channel_select;
         ch_s2_q <= ch_s1_q;
         ext_s1_q <= ext_trigger;
         ext_s2_q <= ext_s1_q;
         ext_s3_q <= ext_s2_q;
      end
   end

   // The base rate is a tick enable; the high rate ticks on every clock.
   assign base_div = sel_s2_q ? 4'(`APD_BASE_HI_DIV) : 4'(`APD_BASE_LO_DIV);

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pre_q <= 4'h0;
         base_tick_q <= 1'b0;
      end else if (pre_q >= base_div - 4'h1) begin
         pre_q <= 4'h0;
         base_tick_q <= 1'b1;
      end else begin
         pre_q <= pre_q + 4'h1;
         base_tick_q <= 1'b0;
      end
   end

   // Register writes; a mode write rearms the byte pointer of its counter.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ctrl_q <= `APD_CTRL_RESET;
         pacer_en_q <= `APD_PACER_EN_RESET;
         div1_lo_q <= 8'h00;
         div1_hi_q <= 8'h00;
         div2_lo_q <= 8'h00;
         div2_hi_q <= 8'h00;
         div1_hi_next_q <= 1'b0;
         div2_hi_next_q <= 1'b0;
         mode1_q <= 1'b0;
         mode2_q <= 1'b0;
         load1_q <= 1'b0;
         load2_q <= 1'b0;
      end else begin
         load1_q <= 1'b0;
         load2_q <= 1'b0;
         if (link.io_wr) begin
            case (link.io_addr)
               `APD_OFF_DMA_CTRL: ctrl_q <= link.io_wdata;
               `APD_OFF_PACER_EN: pacer_en_q <= link.io_wdata;
               `APD_OFF_MODE: begin
                  if (link.io_wdata == `APD_MODE_CNT1_SQ) begin
                     mode1_q <= 1'b1;
                     div1_hi_next_q <= 1'b0;
                  end
                  if (link.io_wdata == `APD_MODE_CNT2_SQ) begin
                     mode2_q <= 1'b1;
                     div2_hi_next_q <= 1'b0;
                  end
               end
               `APD_OFF_DIV1: begin
                  if (div1_hi_next_q) begin
                     div1_hi_q <= link.io_wdata;
                     load1_q <= 1'b1;
                  end else begin
                     div1_lo_q <= link.io_wdata;
                  end
                  div1_hi_next_q <= ~div1_hi_next_q;
               end
               `APD_OFF_DIV2: begin
                  if (div2_hi_next_q) begin
                     div2_hi_q <= link.io_wdata;
                     load2_q <= 1'b1;
                  end else begin
                     div2_lo_q <= link.io_wdata;
                  end
                  div2_hi_next_q <= ~div2_hi_next_q;
               end
               default: ;
            endcase
         end
      end
   end

   // Counter zero is not built; its offset reads as zero.
   apd_sq_counter u_first (
      .clock(clock),
      .rstn(rstn),
      .armed(mode1_q),
      .load(load1_q),
      .divisor({div1_hi_q, div1_lo_q}),
      .tick(base_tick_q & ~pacer_en_q[0]),
      .out_q(out1),
      .edge_q(edge1)
   );

   // The falling edge of counter one is the clock of counter two.
   apd_sq_counter u_second (
      .clock(clock),
      .rstn(rstn),
      .armed(mode2_q),
      .load(load2_q),
      .divisor({div2_hi_q, div2_lo_q}),
      .tick(edge1),
      .out_q(out2),
      .edge_q(edge2)
   );

   always_comb begin
      case (ctrl_q[1:0])
         `APD_SRC_PACER: trig = edge2 & ~pacer_en_q[0];
         `APD_SRC_EXT: trig = ext_s2_q & ~ext_s3_q;
         default: trig = 1'b0;
      endcase
   end

   // Request holds until acknowledged or the DMA enable bit is cleared; a new trigger in an acknowledge cycle wins.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         conv_start_q <= 1'b0;
         req_q <= 1'b0;
         dma_ch1_req_q <= 1'b0;
         dma_ch3_req_q <= 1'b0;
      end else begin
         conv_start_q <= trig;
         if (trig && ctrl_q[`APD_CTRL_DMA_EN_BIT]) begin
            req_q <= 1'b1;
         end else if (link.dma_ack || !ctrl_q[`APD_CTRL_DMA_EN_BIT]) begin
            req_q <= 1'b0;
         end
         dma_ch1_req_q <= req_q & ~ch_s2_q;
         dma_ch3_req_q <= req_q & ch_s2_q;
      end
   end

   assign link.dma_req = req_q;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rdata_q <= 8'h00;
      end else if (link.io_rd) begin
         case (link.io_addr)
            `APD_OFF_DMA_CTRL: rdata_q <= ctrl_q;
            `APD_OFF_PACER_EN: rdata_q <= pacer_en_q;
            `APD_OFF_DIV1: rdata_q <= div1_hi_next_q ? div1_lo_q : div1_hi_q;
            `APD_OFF_DIV2: rdata_q <= div2_hi_next_q ? div2_lo_q : div2_hi_q;
            `APD_OFF_STATUS: rdata_q <= {4'h0, req_q, out2, out1, mode2_q & mode1_q};
            default: rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign link.io_rdata = rdata_q;
endmodule

// File: rtl/apd_host.sv
/*
 Host end: passes software byte I/O cycles onto the link and answers DMA
 requests with an acknowledge, counting transfers. Assumes the same clock.
*/
`timescale 1ns/1ps
`include "apd_consts.svh"
module apd_host (
   input wire logic clock,
   input wire logic rstn,
   apd_link_if.host link,
   input wire logic [3:0] sw_addr,
   input wire logic [7:0] sw_wdata,
   input wire logic sw_wr,
   input wire logic sw_rd,
   input wire logic dma_enable,
   output logic [7:0] sw_rdata_q,
   output logic [15:0] xfer_count_q
);
   import apd_pkg::*;
   apd_host_state_t state_q;
   logic [3:0] addr_q;
   logic [7:0] wdata_q;
   logic wr_q, rd_q, rd_d1_q, ack_q;

   // Software sequences setup as the channel is armed by dma_enable.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         addr_q <= 4'h0;
         wdata_q <= 8'h00;
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         rd_d1_q <= 1'b0;
         sw_rdata_q <= 8'h00;
      end else begin
         addr_q <= sw_addr;
         wdata_q <= sw_wdata;
         wr_q <= sw_wr;
         rd_q <= sw_rd;
         rd_d1_q <= rd_q;
         if (rd_d1_q) begin
            sw_rdata_q <= link.io_rdata;
         end
      end
   end

   assign link.io_addr = addr_q;
   assign link.io_wdata = wdata_q;
   assign link.io_wr = wr_q;
   assign link.io_rd = rd_q;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_q <= APD_H_IDLE;
         ack_q <= 1'b0;
         xfer_count_q <= 16'h0000;
      end else begin
         case (state_q)
            APD_H_IDLE: begin
               if (link.dma_req && dma_enable) begin
                  state_q <= APD_H_ACK;
                  ack_q <= 1'b1;
               end
            end
            APD_H_ACK: begin
               ack_q <= 1'b0;
               xfer_count_q <= xfer_count_q + 16'h0001;
               state_q <= APD_H_WAIT;
            end
            APD_H_WAIT: state_q <= APD_H_IDLE;
            default: state_q <= APD_H_IDLE;
         endcase
      end
   end

   assign link.dma_ack = ack_q;
endmodule

// File: sim/apd_asserts.sv
/*
 Checker on the link between the device end and the host end.
 Assumes one clock and the host always answering DMA requests.
*/
`timescale 1ns/1ps
module apd_asserts (
   input wire logic clock,
   input wire logic rstn,
   input wire logic [3:0] io_addr,
   input wire logic [7:0] io_wdata,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_rdata,
   input wire logic dma_req,
   input wire logic dma_ack
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);
   sequence served_s;
      dma_req ##1 dma_ack ##1 !dma_req;
   endsequence
   strobe_excl_a: assert property (!(io_wr && io_rd))
      else $error("read and write strobes together");
   rdata_idle_a: assert property (!$past(io_rd) |-> io_rdata == 8'h00)
      else $error("read data outside its cycle");
   unmapped_read_a: assert property (io_rd &&
      !(io_addr inside {4'h0, 4'h9, 4'ha, 4'hd, 4'he, 4'hf}) |=> io_rdata == 8'h00)
      else $error("unmapped read not zero");
   req_served_a: assert property ($rose(dma_req) |-> served_s)
      else $error("request not served in order");
   ack_cause_a: assert property (dma_ack |-> $past(dma_req))
      else $error("acknowledge without request");
   ack_pulse_a: assert property (dma_ack |=> !dma_ack)
      else $error("acknowledge longer than one cycle");
   req_hold_a: assert property (dma_req && !dma_ack |=> dma_req)
      else $error("request dropped before acknowledge");
   req_drop_a: assert property (dma_ack |=> !dma_req)
      else $error("request kept after acknowledge");
endmodule

// File: sim/acq_pacer_dma_request_tb.sv
/*
 Bench for both ends of the pacer and DMA link, joined by the interface.
 Assumes the designer's header and package are compiled first.
*/
`timescale 1ns/1ps
`include "apd_consts.svh"
`define CHK(nm,e,g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
 $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module acq_pacer_dma_request_tb;
   import apd_pkg::*;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic bsel = 1'b1;
   logic chsel = 1'b0;
   logic ext = 1'b0;
   logic sw_wr = 1'b0;
   logic sw_rd = 1'b0;
   logic dma_en = 1'b1;
   logic conv, ch1, ch3;
   logic req_q = 1'b0;
   logic [2:0] chq = 3'h0;
   logic dma_on = 1'b0;
   apd_byte_t sw_rdata;
   int pend[$];
   int cyc = 0;
   int lag;
   logic [15:0] xfer, x0;
   logic [7:0] lfsr = 8'h04;
   apd_addr_t sw_addr = 4'h0;
   apd_byte_t sw_wdata = 8'h00;
   apd_byte_t rdat;
   int num_errors = 0;
   int n_checks = 0;
   int per, i;
   always #50 clock = ~clock;
   apd_link_if apd_link_if_i ();
   apd_device apd_device_i (.clock(clock), .rstn(rstn), .link(apd_link_if_i.dev),
      .base_clock_select(bsel), .dma_channel_select(chsel), .ext_trigger(ext),
      .conv_start_q(conv), .dma_ch1_req_q(ch1), .dma_ch3_req_q(ch3));
   apd_host apd_host_i (.clock(clock), .rstn(rstn), .link(apd_link_if_i.host),
      .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
      .dma_enable(dma_en), .sw_rdata_q(sw_rdata), .xfer_count_q(xfer));
   apd_asserts apd_asserts_i (.clock(clock), .rstn(rstn), .io_addr(apd_link_if_i.io_addr),
      .io_wdata(apd_link_if_i.io_wdata), .io_wr(apd_link_if_i.io_wr),
      .io_rd(apd_link_if_i.io_rd), .io_rdata(apd_link_if_i.io_rdata),
      .dma_req(apd_link_if_i.dma_req), .dma_ack(apd_link_if_i.dma_ack));
   function automatic int rnd();
      lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      return int'(lfsr % 8) + 2;
   endfunction
   // The select pin passes two synchroniser stages before it steers the request,
   // so the model delays it too. Each trigger with DMA on queues one transfer.
   always @(posedge clock) begin
      req_q <= apd_link_if_i.dma_req;
      chq <= {chq[1:0], chsel};
      cyc++;
      if (rstn) begin
         `CHK("ch1", req_q & ~chq[2], ch1)
         `CHK("ch3", req_q & chq[2], ch3)
         if (conv === 1'b1 && dma_on) begin
            pend.push_back(cyc);
         end
         if (apd_link_if_i.dma_ack === 1'b1) begin
            lag = (pend.size() > 0) ? cyc - pend.pop_front() : 0;
            `CHK("ack delay", 1, lag)
         end
      end
   end
   task give_verdict;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task wr(input apd_addr_t a, input apd_byte_t d);
      if (a == `APD_OFF_DMA_CTRL) begin
         dma_on = d[`APD_CTRL_DMA_EN_BIT];
      end
      @(posedge clock);
      sw_addr <= a;
      sw_wdata <= d;
      sw_wr <= 1'b1;
      @(posedge clock);
      sw_wr <= 1'b0;
   endtask
   // The host end adds a stage each way, so its read data settle three edges on.
   task rd(input apd_addr_t a);
      @(posedge clock);
      sw_addr <= a;
      sw_rd <= 1'b1;
      @(posedge clock);
      sw_rd <= 1'b0;
      repeat (3) @(posedge clock);
      rdat = sw_rdata;
   endtask
   task trig(input int lim);
      per = 0;
      do begin
         @(posedge clock);
         #1;
         per++;
      end while (conv !== 1'b1 && per < lim);
   endtask
   task prog(input int n1, input int n2);
      wr(`APD_OFF_MODE, `APD_MODE_CNT1_SQ);
      wr(`APD_OFF_DIV1, n1[7:0]);
      wr(`APD_OFF_DIV1, n1[15:8]);
      wr(`APD_OFF_MODE, `APD_MODE_CNT2_SQ);
      wr(`APD_OFF_DIV2, n2[7:0]);
      wr(`APD_OFF_DIV2, n2[15:8]);
   endtask
   // Two triggers are dropped so that the reload has settled.
   task pace(input int n1, input int n2, input int dv);
      prog(n1, n2);
      trig(4000);
      trig(4000);
      trig(4000);
      `CHK("period", n1 * n2 * dv, per)
      $display("test period %0d done", per);
   endtask
   initial begin
      repeat (5) @(posedge clock);
      rstn <= 1'b1;
      rd(`APD_OFF_DMA_CTRL);
      `CHK("ctrl reset", `APD_CTRL_RESET, rdat)
      rd(`APD_OFF_PACER_EN);
      `CHK("enable reset", `APD_PACER_EN_RESET, rdat)
      rd(4'hc);
      `CHK("unmapped", 8'h00, rdat)
      wr(`APD_OFF_MODE, 8'h36);
      wr(`APD_OFF_MODE, `APD_MODE_CNT1_SQ);
      rd(`APD_OFF_STATUS);
      `CHK("one mode", 8'h00, rdat & 8'h01)
      prog(3, 2);
      rd(`APD_OFF_STATUS);
      `CHK("both modes", 8'h01, rdat & 8'h01)
      rd(`APD_OFF_DIV1);
      `CHK("div1 back", 8'h00, rdat)
      wr(`APD_OFF_DMA_CTRL, 8'h07);
      trig(300);
      `CHK("disabled", 300, per)
      $display("test setup done");
      wr(`APD_OFF_PACER_EN, 8'h00);
      pace(2, 2, 1);
      for (i = 0; i < 3; i++) begin
         pace(rnd(), rnd(), 1);
      end
      repeat (3) @(posedge clock);
      #1;
      x0 = xfer;
      trig(4000);
      trig(4000);
      repeat (3) @(posedge clock);
      #1;
      `CHK("xfer", x0 + 16'h0002, xfer)
      $display("test dma done");
      @(posedge clock);
      chsel <= 1'b1;
      bsel <= 1'b0;
      pace(3, 2, 10);
      wr(`APD_OFF_DMA_CTRL, 8'h04);
      trig(300);
      `CHK("no source", 300, per)
      wr(`APD_OFF_DMA_CTRL, 8'h06);
      @(posedge clock);
      ext <= 1'b1;
      trig(20);
      `CHK("external", 1'b1, per < 20)
      $display("test sources done");
      give_verdict;
   end
   initial begin
      repeat (20000) @(posedge clock);
      num_errors++;
      give_verdict;
   end
endmodule
